// >>> hdl/tos_defs.svh
`ifndef TOS_DEFS_SVH
`define TOS_DEFS_SVH
// Purpose: constants of the timed output scheduler
// Assumes: 40 MHz clock
// Notes: byte offsets are within one four-byte entry
`define TOS_INPUT_LEN 8'h04
`define TOS_OUTPUT_LEN_SMALL 8'h14
`define TOS_OUTPUT_LEN_LARGE 8'h3c
`define TOS_RECORD_SET 8'h02
`define TOS_IDX_INPUT_LEN 16'h3100
`define TOS_IDX_OUTPUT_LEN 16'h3101
`define TOS_SUB_INPUT_LEN 8'h01
`define TOS_SUB_OUTPUT_LEN 8'h02
`define TOS_ENTRIES_SMALL 5
`define TOS_ENTRIES_LARGE 15
`define TOS_FIFO_DEPTH 32
`define TOS_OFS_STATE 2'h0
`define TOS_OFS_SEQ 2'h1
`define TOS_OFS_DUE 2'h2
`define TOS_SEQ_LAST_BIT 6
`define TOS_CLK_HZ 40000000
`define TOS_US_PER_S 1000000
`define TOS_CYC_PER_US (`TOS_CLK_HZ / `TOS_US_PER_S)
`define TOS_STS_PARTIAL_BIT 7
`define TOS_STS_FULL_BIT 0
`define TOS_STS_ACTIVE_BIT 1
`endif

// >>> hdl/tos_pkg.sv
// Purpose: types of the timed output scheduler
// Assumes: nothing
// Notes: one entry is four bytes, state/seq/due
package tos_pkg;
	typedef struct packed
	{
		logic [7:0] state;
		logic [7:0] seq;
		logic [15:0] due;
	} tos_entry_s;
	typedef struct packed
	{
		logic [7:0] lastWritten;
		logic [7:0] nextDue;
		logic [7:0] queueStatus;
		logic [7:0] queuedCount;
	} tos_status_s;
endpackage : tos_pkg

// >>> hdl/tos_entry_mem.sv
// Purpose: entry memory of the scheduler queue
// Assumes: one write, one clear and one read port, same clock
// Notes: read data registered; cleared slots read as zero
`include "tos_defs.svh"
module tos_entry_mem
(
	input wire logic clk,
	input wire logic rst,
	input wire logic wrEn,
	input wire logic [4:0] wrAddr,
	input wire tos_pkg::tos_entry_s wrData,
	input wire logic clrEn,
	input wire logic [4:0] clrAddr,
	input wire logic [4:0] rdAddr,
	output tos_pkg::tos_entry_s rdData
);
	tos_pkg::tos_entry_s mem [`TOS_FIFO_DEPTH];

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < `TOS_FIFO_DEPTH; i++)
				mem[i] <= '0;
		end
		else
		begin
			if (clrEn)
				mem[clrAddr] <= '0;
			if (wrEn)
				mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdData <= '0;
		else if (wrEn && wrAddr == rdAddr)
			rdData <= wrData;
		else if (clrEn && clrAddr == rdAddr)
			rdData <= '0;
		else
			rdData <= mem[rdAddr];
	end
endmodule : tos_entry_mem

// >>> hdl/tos_scheduler.sv
// Purpose: four-channel timed output scheduler
// Assumes: host writes the output image bytewise, one byte per cycle
// Notes: the large variant is selected by a pin sampled after reset
`include "tos_defs.svh"
module tos_scheduler
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic variantLarge,
	input wire logic imageWrEn,
	input wire logic [5:0] imageWrAddr,
	input wire logic [7:0] imageWrData,
	input wire logic imageCommit,
	input wire logic [1:0] inputRdAddr,
	output logic [7:0] inputRdData,
	input wire logic paramRdEn,
	input wire logic [7:0] paramRecord,
	input wire logic [15:0] paramIndex,
	input wire logic [7:0] paramSubindex,
	input wire logic paramWrEn,
	input wire logic [7:0] paramWrData,
	output logic [7:0] paramRdData,
	output logic paramRdValid,
	output logic [3:0] channelOut,
	output logic [31:0] tickerUs
);
	localparam int ImageBytes = 60;
	localparam int CycPerUs = `TOS_CYC_PER_US;

	logic rstMeta, rstSync, rst;
	logic varMeta, varSync, isLarge;
	logic [7:0] image [ImageBytes];
	logic [5:0] cycCnt;
	logic [4:0] wrPtr, rdPtr, pushIdx;
	logic [5:0] count;
	logic pushing;
	logic [3:0] pushLeft;
	logic [7:0] lastWritten, queueStatus;
	logic headValid;
	logic [1:0] headWait;
	tos_pkg::tos_entry_s pushEntry, headEntry;
	tos_pkg::tos_status_s status;
	logic pushWr, popNow;
	logic [7:0] outputLen;
	logic [5:0] base;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end
		else
		begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end
	assign rst = !rstSync;

	// variant strap is a pin: two flops, then caught once out of reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			varMeta <= 1'b0;
			varSync <= 1'b0;
		end
		else
		begin
			varMeta <= variantLarge;
			varSync <= varMeta;
		end
	end

	// wait until the synchroniser holds a real sample; its reset zero is not one
	logic [1:0] varAge;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			isLarge <= 1'b0;
			varAge <= 2'h0;
		end
		else if (varAge != 2'h3)
		begin
			varAge <= varAge + 2'h1;
			if (varAge == 2'h2)
				isLarge <= varSync;
		end
	end

	// ticker: microsecond prescaler and 32-bit count, wraps naturally
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cycCnt <= '0;
			tickerUs <= '0;
		end
		else if (cycCnt == 6'(CycPerUs - 1))
		begin
			cycCnt <= '0;
			tickerUs <= tickerUs + 32'h1;
		end
		else
			cycCnt <= cycCnt + 6'h1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < ImageBytes; i++)
				image[i] <= '0;
		end
		else if (imageWrEn && imageWrAddr < outputLen[5:0])
			image[imageWrAddr] <= imageWrData;
	end

	assign outputLen = isLarge ? `TOS_OUTPUT_LEN_LARGE : `TOS_OUTPUT_LEN_SMALL;
	assign base = {pushIdx[3:0], 2'b00};
	always_comb
	begin
		pushEntry.state = image[base + 6'(`TOS_OFS_STATE)];
		pushEntry.seq = image[base + 6'(`TOS_OFS_SEQ)];
		pushEntry.due = {image[base + 6'(`TOS_OFS_DUE) + 6'h1], image[base + 6'(`TOS_OFS_DUE)]};
	end

	// commit walks the slots in order; a slot after a marked last entry is skipped
	assign pushWr = pushing && count < 6'(`TOS_FIFO_DEPTH - 1);
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pushing <= 1'b0;
			pushLeft <= '0;
			pushIdx <= '0;
			lastWritten <= '0;
		end
		else if (!pushing && imageCommit)
		begin
			pushing <= 1'b1;
			pushIdx <= '0;
			pushLeft <= isLarge ? 4'(`TOS_ENTRIES_LARGE - 1) : 4'(`TOS_ENTRIES_SMALL - 1);
		end
		else if (pushWr)
		begin
			lastWritten <= pushEntry.seq;
			pushIdx <= pushIdx + 5'h1;
			pushLeft <= pushLeft - 4'h1;
			if (pushLeft == 4'h0 || pushEntry.seq[`TOS_SEQ_LAST_BIT])
				pushing <= 1'b0;
		end
	end

	// apply when the head is due; read latency covered by headWait
	assign popNow = headValid && headWait == 2'h0
		&& headEntry.due == tickerUs[15:0] && count != 6'h0;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
			headWait <= 2'h2;
			headValid <= 1'b0;
			channelOut <= '0;
		end
		else
		begin
			if (pushWr)
				wrPtr <= wrPtr + 5'h1;
			if (popNow)
			begin
				rdPtr <= rdPtr + 5'h1;
				channelOut <= {headEntry.state[4], headEntry.state[5],
					headEntry.state[6], headEntry.state[7]};
			end
			count <= count + 6'(pushWr) - 6'(popNow);
			headValid <= count != 6'h0 || pushWr;
			headWait <= (popNow || pushWr) ? 2'h2 : (headWait == 2'h0 ? 2'h0 : headWait - 2'h1);
		end
	end

	tos_entry_mem u_mem
	(
		.clk(clk),
		.rst(rst),
		.wrEn(pushWr),
		.wrAddr(wrPtr),
		.wrData(pushEntry),
		.clrEn(popNow),
		.clrAddr(rdPtr),
		.rdAddr(rdPtr),
		.rdData(headEntry)
	);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			queueStatus <= '0;
		else
		begin
			queueStatus <= '0;
			queueStatus[`TOS_STS_PARTIAL_BIT] <= lastWritten[`TOS_SEQ_LAST_BIT];
			queueStatus[`TOS_STS_ACTIVE_BIT] <= count != 6'h0;
			queueStatus[`TOS_STS_FULL_BIT] <= count >= 6'(`TOS_FIFO_DEPTH - 1);
		end
	end

	always_comb
	begin
		status.lastWritten = lastWritten;
		status.nextDue = (count != 6'h0) ? headEntry.seq : 8'h00;
		status.queueStatus = queueStatus;
		status.queuedCount = {2'b00, count};
	end

	// input image is exactly four bytes
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			inputRdData <= '0;
		else
			unique case (inputRdAddr)
				2'h0: inputRdData <= status.lastWritten;
				2'h1: inputRdData <= status.nextDue;
				2'h2: inputRdData <= status.queueStatus;
				2'h3: inputRdData <= status.queuedCount;
			endcase
	end

	// parameter write data has no path to any register; a write is answered like a read
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			paramRdData <= '0;
			paramRdValid <= 1'b0;
		end
		else
		begin
			paramRdValid <= paramRdEn || paramWrEn;
			paramRdData <= '0;
			if ((paramRecord == `TOS_RECORD_SET && paramSubindex == `TOS_SUB_INPUT_LEN)
				|| paramIndex == `TOS_IDX_INPUT_LEN)
				paramRdData <= `TOS_INPUT_LEN;
			else if ((paramRecord == `TOS_RECORD_SET && paramSubindex == `TOS_SUB_OUTPUT_LEN)
				|| paramIndex == `TOS_IDX_OUTPUT_LEN)
				paramRdData <= outputLen;
		end
	end
endmodule : tos_scheduler

// >>> testbench/tos_scheduler_checker.sv
// Purpose: port assertions of the scheduler
// Assumes: variant pin held steady
// Notes: bound after endmodule
module tos_scheduler_checker
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic paramRdEn,
	input wire logic paramWrEn,
	input wire logic [7:0] paramRecord,
	input wire logic [15:0] paramIndex,
	input wire logic [7:0] paramSubindex,
	input wire logic [7:0] paramRdData,
	input wire logic paramRdValid,
	input wire logic [31:0] tickerUs,
	input wire logic variantLarge
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	a_tick_step: assert property
		($changed(tickerUs) |-> tickerUs == $past(tickerUs) + 32'h1) else $error("ticker jump");
	a_tick_hold: assert property
		($changed(tickerUs) |=> $stable(tickerUs) [*8]) else $error("ticker too fast");
	a_rd_answer: assert property
		(paramRdEn |=> paramRdValid) else $error("read unanswered");
	a_rd_cause: assert property
		(paramRdValid |-> $past(paramRdEn || paramWrEn)) else $error("stray valid");
	a_wr_inert: assert property
		(paramWrEn && paramRecord == 8'h02 && paramSubindex == 8'h02
		|=> paramRdValid && paramRdData == (variantLarge ? 8'h3c : 8'h14))
		else $error("write altered length");
	a_in_len_rec: assert property
		(paramRdEn && paramRecord == 8'h02 && paramSubindex == 8'h01 |=> paramRdData == 8'h04)
		else $error("input length");
	a_in_len_idx: assert property
		(paramRdEn && paramIndex == 16'h3100 |=> paramRdData == 8'h04) else $error("index 3100");
	a_out_len: assert property
		(paramRdEn && paramIndex == 16'h3101 |=> paramRdData == (variantLarge ? 8'h3c : 8'h14))
		else $error("output length");
endmodule : tos_scheduler_checker
bind tos_scheduler tos_scheduler_checker tos_scheduler_checker_i (.clk, .rstn, .paramRdEn,
	.paramWrEn, .paramRecord, .paramIndex, .paramSubindex, .paramRdData, .paramRdValid,
	.tickerUs, .variantLarge);

// >>> testbench/tos_host_model.sv
// Purpose: host side driving image and parameter requests
// Assumes: drives on the falling edge
// Notes: released image data shows its inverse, never the stale byte
module tos_host_model
(
	input wire logic clk,
	output logic imageWrEn,
	output logic [5:0] imageWrAddr,
	output logic [7:0] imageWrData,
	output logic imageCommit,
	output logic [1:0] inputRdAddr,
	input wire logic [7:0] inputRdData,
	output logic paramRdEn,
	output logic paramWrEn,
	output logic [7:0] paramRecord,
	output logic [15:0] paramIndex,
	output logic [7:0] paramSubindex,
	output logic [7:0] paramWrData,
	input wire logic [7:0] paramRdData
);
	timeunit 1ns;
	timeprecision 100ps;
	initial {imageWrEn, imageWrAddr, imageWrData, imageCommit, inputRdAddr, paramRdEn,
		paramWrEn, paramRecord, paramIndex, paramSubindex, paramWrData} = '0;
	task put_entry(input logic [5:0] base, input tos_pkg::tos_entry_s e);
		logic [31:0] w;
		// byte order in the image: state, sequence, due low, due high
		w = {e.state, e.seq, e.due[7:0], e.due[15:8]};
		for (int k = 0; k < 4; k++)
		begin
			@(negedge clk);
			imageWrEn = 1'b1;
			imageWrAddr = base + 6'(k);
			imageWrData = w[31-8*k-:8];
		end
		@(negedge clk);
		imageWrEn = 1'b0;
		imageWrData = ~imageWrData;
	endtask : put_entry
	task commit;
		@(negedge clk);
		imageCommit = 1'b1;
		@(negedge clk);
		imageCommit = 1'b0;
	endtask : commit
	task status(input logic [1:0] a, output logic [7:0] d);
		@(negedge clk);
		inputRdAddr = a;
		@(negedge clk);
		d = inputRdData;
	endtask : status
	// only called while the queue is empty: before any queueing, or after the second reset
	task param(input logic [7:0] r, input logic [15:0] x, input logic [7:0] s,
		input logic wr, output logic [7:0] d);
		@(negedge clk);
		paramRecord = r;
		paramIndex = x;
		paramSubindex = s;
		paramRdEn = !wr;
		paramWrEn = wr;
		paramWrData = 8'hff;
		@(negedge clk);
		paramRdEn = 1'b0;
		paramWrEn = 1'b0;
		d = paramRdData;
		{paramRecord, paramIndex, paramSubindex} = ~{paramRecord, paramIndex, paramSubindex};
	endtask : param
endmodule : tos_host_model

// >>> testbench/tos_scheduler_tb_top.sv
// Purpose: self-checking bench of the scheduler
// Assumes: small variant, then large after a second reset
// Notes: due times short since the ticker rate is fixed
module tos_scheduler_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic variantLarge = 1'b0;
	logic imageWrEn, imageCommit, paramRdEn, paramWrEn, paramRdValid;
	logic [1:0] inputRdAddr;
	logic [3:0] channelOut;
	logic [5:0] imageWrAddr;
	logic [7:0] imageWrData, inputRdData, paramRecord, paramSubindex, paramWrData, paramRdData;
	logic [15:0] paramIndex;
	logic [31:0] tickerUs;
	int num_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	always #12.5 clk = ~clk;
	tos_scheduler tos_scheduler_i (.clk, .rstn, .variantLarge, .imageWrEn, .imageWrAddr,
		.imageWrData, .imageCommit, .inputRdAddr, .inputRdData, .paramRdEn, .paramRecord,
		.paramIndex, .paramSubindex, .paramWrEn, .paramWrData, .paramRdData, .paramRdValid,
		.channelOut, .tickerUs);
	tos_host_model tos_host_model_i (.clk, .imageWrEn, .imageWrAddr, .imageWrData, .imageCommit,
		.inputRdAddr, .inputRdData, .paramRdEn, .paramWrEn, .paramRecord, .paramIndex,
		.paramSubindex, .paramWrData, .paramRdData);
	task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %s exp %h seen %h", n, exp, seen);
		end
	endtask : check
	task give_verdict;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	// about 3300 cycles expected
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			num_errors++;
			give_verdict();
		end
	end
	task test_params;
		logic [7:0] d;
		logic [7:0] r [6] = '{8'h02, 8'h00, 8'h02, 8'h00, 8'h02, 8'h02};
		logic [15:0] x [6] = '{16'h0, 16'h3101, 16'h0, 16'h3100, 16'h0, 16'h0};
		logic [7:0] s [6] = '{8'h01, 8'h00, 8'h02, 8'h00, 8'h02, 8'h02};
		logic [7:0] e [6] = '{8'h04, 8'h14, 8'h14, 8'h04, 8'h00, 8'h14};
		// row 4 writes, row 5 proves the write was ignored
		for (int i = 0; i < 6; i++)
		begin
			tos_host_model_i.param(r[i], x[i], s[i], i == 4, d);
			if (i != 4)
				check("paramData", d, e[i]);
		end
		$display("params done");
	endtask : test_params
	task test_queue;
		logic [7:0] d;
		logic [31:0] t;
		tos_pkg::tos_entry_s q [3] = '{'{8'hb0, 8'h01, 16'd40}, '{8'h70, 8'h02, 16'd60},
			'{8'h50, 8'h43, 16'd80}};
		// channel 0 in bit 0: b0 -> d, 70 -> e, 50 -> a
		logic [3:0] c [3] = '{4'hd, 4'he, 4'ha};
		t = tickerUs;
		repeat (40) @(negedge clk);
		check("ticker", tickerUs, t + 32'h1);
		// short batch: final sequence carries bit 6
		for (int i = 0; i < 3; i++)
			tos_host_model_i.put_entry(6'(4 * i), q[i]);
		tos_host_model_i.commit();
		repeat (16) @(negedge clk);
		tos_host_model_i.status(2'h3, d);
		check("count", d, 32'h3);
		tos_host_model_i.status(2'h0, d);
		check("last", d, 32'h43);
		tos_host_model_i.status(2'h2, d);
		check("qstatus", d, 32'h82);
		for (int i = 0; i < 3; i++)
		begin
			while (tickerUs[15:0] !== q[i].due + 16'h1)
				@(negedge clk);
			check("chan", channelOut, c[i]);
			tos_host_model_i.status(2'h3, d);
			check("count", d, 32'(2 - i));
		end
		$display("queue done");
	endtask : test_queue
	// second reset in mid-run; the variant strap is only caught after reset
	task test_large;
		logic [7:0] d;
		@(negedge clk);
		rstn = 1'b0;
		variantLarge = 1'b1;
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		repeat (8) @(negedge clk);
		tos_host_model_i.param(8'h00, 16'h3101, 8'h00, 1'b0, d);
		check("paramLarge", d, 32'h3c);
		tos_host_model_i.param(8'h02, 16'h0000, 8'h02, 1'b0, d);
		check("recordLarge", d, 32'h3c);
		tos_host_model_i.status(2'h3, d);
		check("countReset", d, 32'h0);
		$display("large done");
	endtask : test_large
	initial
	begin
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		repeat (8) @(negedge clk);
		test_params();
		test_queue();
		test_large();
		give_verdict();
	end
endmodule : tos_scheduler_tb_top
